// File: verilog/cpw_pkg.sv
`default_nettype none
package cpw_pkg;
    localparam logic [9:0] CPW_IDX_DUTY_LO = 10'h028;
    localparam logic [9:0] CPW_IDX_DUTY_HI = 10'h029;
    localparam logic [11:0] CPW_ADDR_DUTY_LO = {CPW_IDX_DUTY_LO, 2'h0};
    localparam logic [11:0] CPW_ADDR_DUTY_HI = {CPW_IDX_DUTY_HI, 2'h0};
    localparam logic [11:0] CPW_ADDR_MODE = 12'h100;
    localparam logic [11:0] CPW_ADDR_CTRL = 12'h104;
    localparam logic [11:0] CPW_ADDR_STATUS = 12'h108;
    localparam logic [7:0] CPW_DUTY_LO_RST = 8'hFF;
    localparam logic [7:0] CPW_DUTY_HI_RST = 8'hFF;
    localparam logic [7:0] CPW_MODE_RST = 8'h00;
    localparam int CPW_MODE_LEVEL_BIT = 0;
    localparam int CPW_MODE_DBUF_BIT = 1;
    localparam int CPW_MODE_FIELD_LSB = 2;
    localparam logic [1:0] CPW_MODE_PWM = 2'h2;
    localparam int CPW_MODE_EXTCLK_BIT = 4;
    localparam int CPW_CTRL_LOWER_RUN_BIT = 1;
    localparam int CPW_CTRL_UPPER_RUN_BIT = 2;
    localparam int CPW_CTRL_CASCADE_BIT = 0;
    localparam logic [7:0] CPW_COUNT_RST = 8'h00;
    localparam logic [3:0] CPW_CYCLE_RST = 4'h0;
    localparam logic [3:0] CPW_CYCLE_LAST = 4'hF;
endpackage : cpw_pkg
`default_nettype wire

// File: verilog/cpw_pwm12.sv
// Contract
// [RL1] high nibble spare bits store and read back
// [RL2] duty value from high and low nibbles
// [RL3] select bits map to fixed frame cycles
// [RL4] select bits add up stretched cycles
// [RL5] stopped output shows initial level
// [RL6] duty match inverts output while running
// [RL7] selected cycle inverts one count later
// [RL8] zero selector stretches nothing
// [RL9] overflow clears counter, restores level
// [RL10] overflow pulse each cycle, frame every 16th
// [RL11] clearing run stops, clears, restores level
// [RL12] external clock at most half rate, wide phases
// [RL13] buffer enable picks buffered or direct
// [RL14] buffered writes load at frame overflow
// [RL15] reads return last written buffered value
// [RL16] stopped write loads active value immediately
// [RL17] unbuffered running write takes effect at once
// [RL18] low written first, commit on high write
// [RL19] pwm mode needs cascade and field 10
// [RL20] mode writes ignored while running
// [RL21] cycle index advances per overflow, wraps 16
`default_nettype none
module cpw_pwm12
    import cpw_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic src_tick_i,
    input wire logic external_count_pin_i,
    output logic pwm_output_n_o,
    output logic overflow_irq_o,
    output logic frame_irq_o
);
    logic [7:0] duty_low_register_ff;
    logic [7:0] duty_high_register_ff;
    logic [7:0] pend_lo_ff;
    logic [7:0] active_duty_word_ff;
    logic [3:0] active_pad_ff;
    logic [7:0] upper_mode_register_ff;
    logic [2:0] cascade_control_register_ff;
    logic [7:0] count_ff;
    logic [3:0] cycle_ff;
    logic ext_s1_ff;
    logic ext_s2_ff;
    logic ext_s3_ff;
    logic out_ff;
    logic ovf_ff;
    logic frm_ff;

    // bus decode
    logic setup;
    logic wr_acc;
    logic duty_lo_sel;
    logic duty_hi_sel;
    logic mode_sel;
    logic ctrl_sel;
    logic mode_unlocked;

    // counting and matching
    logic running;
    logic pwm_mode;
    logic ext_fall;
    logic tick;
    logic stretch;
    logic [7:0] duty_value;
    logic [8:0] match_val;
    logic [8:0] count_up;
    logic overflow;
    logic frame_end;
    logic duty_hit;

    // duty commit
    logic duty_commit;
    logic frame_load;
    logic [7:0] commit_duty;
    logic [3:0] commit_pad;

    // next values
    logic [7:0] nxt_count;
    logic [3:0] nxt_cycle;
    logic nxt_out;
    logic nxt_ovf;
    logic nxt_frm;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic [31:0] status_word;

    // cycle n of the frame is index plus one
    function automatic logic cycle_sel(input logic [3:0] sel, input logic [3:0] idx);
        logic [4:0] n;
        n = {1'b0, idx} + 5'h01;
        cycle_sel = (sel[0] && n == 5'h09) ||
                    (sel[1] && n[2:0] == 3'h5) ||
                    (sel[2] && n[1:0] == 2'h3) ||
                    (sel[3] && n[0] == 1'b0);
    endfunction : cycle_sel

    // duty value from the high and low register bytes
    function automatic logic [7:0] duty_of(input logic [7:0] hi, input logic [7:0] lo);
        duty_of = {hi[3:0], lo[7:4]}; // [RL2]
    endfunction : duty_of

    // extra-pulse selector from the low register byte
    function automatic logic [3:0] pad_of(input logic [7:0] lo);
        pad_of = lo[3:0];
    endfunction : pad_of

    // register address hit
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] reg_addr);
        addr_hit = (a == reg_addr);
    endfunction : addr_hit

    // bus decode
    assign setup = psel_i && !penable_i && ce_i;
    assign wr_acc = psel_i && penable_i && pwrite_i && ce_i;
    assign duty_lo_sel = addr_hit(paddr_i, CPW_ADDR_DUTY_LO);
    assign duty_hi_sel = addr_hit(paddr_i, CPW_ADDR_DUTY_HI);
    assign mode_sel = addr_hit(paddr_i, CPW_ADDR_MODE);
    assign ctrl_sel = addr_hit(paddr_i, CPW_ADDR_CTRL);
    assign mode_unlocked = !cascade_control_register_ff[CPW_CTRL_UPPER_RUN_BIT] &&
        !cascade_control_register_ff[CPW_CTRL_LOWER_RUN_BIT]; // [RL20]

    // run state and count source
    assign pwm_mode = cascade_control_register_ff[CPW_CTRL_CASCADE_BIT] &&
        upper_mode_register_ff[CPW_MODE_FIELD_LSB +: 2] == CPW_MODE_PWM; // [RL19]
    assign running = cascade_control_register_ff[CPW_CTRL_UPPER_RUN_BIT] && pwm_mode;
    assign ext_fall = ext_s3_ff && !ext_s2_ff;
    assign tick = upper_mode_register_ff[CPW_MODE_EXTCLK_BIT] ? ext_fall : src_tick_i;

    // compare point, one count later in a stretched cycle
    assign stretch = cycle_sel(active_pad_ff, cycle_ff); // [RL3] [RL4] [RL8] [RL21]
    assign duty_value = active_duty_word_ff; // [RL2]
    assign match_val = {1'b0, duty_value} + {8'h00, stretch}; // [RL7]
    assign count_up = {1'b0, count_ff} + 9'h001;
    assign overflow = ce_i && running && tick && count_ff == 8'hFF; // [RL9]
    assign frame_end = overflow && cycle_ff == CPW_CYCLE_LAST; // [RL10]
    // match as the counter steps onto the compare point, or already sits on it
    assign duty_hit = (tick && count_up == match_val) ||
        ({1'b0, count_ff} == match_val); // [RL6] [RL17]

    // duty commit on the high byte write
    assign duty_commit = wr_acc && duty_hi_sel; // [RL18]
    assign frame_load = frame_end && upper_mode_register_ff[CPW_MODE_DBUF_BIT] &&
        !duty_commit; // [RL14]
    assign commit_duty = duty_of(pwdata_i[7:0], pend_lo_ff); // [RL2]
    assign commit_pad = pad_of(pend_lo_ff);
    assign status_word = {19'h0, out_ff, cycle_ff, count_ff};

    // external count pin synchroniser, falling edge detect after second stage
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else if (ce_i) begin
            ext_s1_ff <= external_count_pin_i; // [RL12]
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    // mode register, locked while either run bit is set
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            upper_mode_register_ff <= CPW_MODE_RST;
        end else if (wr_acc && mode_sel && mode_unlocked) begin
            upper_mode_register_ff <= pwdata_i[7:0]; // [RL20]
        end
    end

    // control register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cascade_control_register_ff <= 3'h0;
        end else if (wr_acc && ctrl_sel) begin
            cascade_control_register_ff <= pwdata_i[2:0];
        end
    end

    // low byte waits here until the high byte commits it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_lo_ff <= CPW_DUTY_LO_RST;
        end else if (wr_acc && duty_lo_sel) begin
            pend_lo_ff <= pwdata_i[7:0]; // [RL18]
        end
    end

    // committed bytes, spare high bits kept for read back
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            duty_low_register_ff <= CPW_DUTY_LO_RST;
            duty_high_register_ff <= CPW_DUTY_HI_RST;
        end else if (duty_commit) begin
            duty_low_register_ff <= pend_lo_ff; // [RL15] [RL18]
            duty_high_register_ff <= pwdata_i[7:0]; // [RL1]
        end
    end

    // active compare word: direct, while stopped, or at the frame end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active_duty_word_ff <= {CPW_DUTY_HI_RST[3:0], CPW_DUTY_LO_RST[7:4]};
            active_pad_ff <= CPW_DUTY_LO_RST[3:0];
        end else if (duty_commit &&
                     (!upper_mode_register_ff[CPW_MODE_DBUF_BIT] || !running)) begin
            active_duty_word_ff <= commit_duty; // [RL13] [RL16] [RL17]
            active_pad_ff <= commit_pad;
        end else if (frame_load) begin
            active_duty_word_ff <= duty_of(duty_high_register_ff,
                                           duty_low_register_ff); // [RL14]
            active_pad_ff <= pad_of(duty_low_register_ff);
        end
    end

    // next count: cleared while stopped and at overflow
    always_comb begin
        nxt_count = count_ff;
        if (!running || overflow) begin
            nxt_count = CPW_COUNT_RST; // [RL9] [RL11]
        end else if (tick) begin
            nxt_count = count_up[7:0];
        end
    end

    // next cycle index: restarts with the timer, wraps after 16
    always_comb begin
        nxt_cycle = cycle_ff;
        if (!running) begin
            nxt_cycle = CPW_CYCLE_RST;
        end else if (overflow) begin
            nxt_cycle = cycle_ff + 4'h1; // [RL21]
        end
    end

    // next level: initial level while stopped and at overflow, inverted at the match
    always_comb begin
        nxt_out = out_ff;
        if (!running) begin
            nxt_out = upper_mode_register_ff[CPW_MODE_LEVEL_BIT]; // [RL5] [RL11]
        end else if (overflow) begin
            nxt_out = upper_mode_register_ff[CPW_MODE_LEVEL_BIT]; // [RL9]
        end else if (duty_hit && out_ff == upper_mode_register_ff[CPW_MODE_LEVEL_BIT]) begin
            nxt_out = !upper_mode_register_ff[CPW_MODE_LEVEL_BIT]; // [RL6]
        end
    end

    // counter
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_ff <= CPW_COUNT_RST;
        end else if (ce_i) begin
            count_ff <= nxt_count;
        end
    end

    // cycle index
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cycle_ff <= CPW_CYCLE_RST;
        end else if (ce_i) begin
            cycle_ff <= nxt_cycle;
        end
    end

    // output level
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_ff <= 1'b0;
        end else if (ce_i) begin
            out_ff <= nxt_out;
        end
    end

    // interrupt pulses: every overflow, and every 16th as frame
    always_comb begin
        nxt_ovf = overflow; // [RL10]
        nxt_frm = frame_end; // [RL10] [RL14]
    end

    // interrupt pulse flops
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ovf_ff <= 1'b0;
            frm_ff <= 1'b0;
        end else if (ce_i) begin
            ovf_ff <= nxt_ovf;
            frm_ff <= nxt_frm;
        end
    end

    // read data and error for the addressed register
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        case (paddr_i)
            CPW_ADDR_DUTY_LO: begin
                nxt_prdata = {24'h00_0000, duty_low_register_ff}; // [RL15]
            end
            CPW_ADDR_DUTY_HI: begin
                nxt_prdata = {24'h00_0000, duty_high_register_ff}; // [RL1] [RL15]
            end
            CPW_ADDR_MODE: begin
                nxt_prdata = {24'h00_0000, upper_mode_register_ff};
            end
            CPW_ADDR_CTRL: begin
                nxt_prdata = {29'h0, cascade_control_register_ff};
            end
            CPW_ADDR_STATUS: begin
                nxt_prdata = status_word;
            end
            default: begin
                nxt_pslverr = 1'b1;
            end
        endcase
    end

    // bus answer: one wait-free access phase after each setup
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            pready_o <= setup;
            pslverr_o <= setup && nxt_pslverr;
            if (setup) begin
                prdata_o <= nxt_prdata;
            end
        end
    end

    assign pwm_output_n_o = out_ff;
    assign overflow_irq_o = ovf_ff;
    assign frame_irq_o = frm_ff;
endmodule : cpw_pwm12
`default_nettype wire

// File: verification/cpw_pwm12_chk.sv
`default_nettype none
module cpw_pwm12_chk (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic src_tick_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic pwm_output_n_o,
    input wire logic overflow_irq_o,
    input wire logic frame_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_setup; psel_i && !penable_i && ce_i; endsequence
    sequence s_done; psel_i && penable_i && pready_o; endsequence
    property p_answer; s_setup |=> s_done; endproperty
    property p_rdy_pulse; pready_o |=> !pready_o; endproperty
    property p_err; pslverr_o && !pwrite_i |-> pready_o && prdata_o == 32'h0; endproperty
    property p_ovf_gap; overflow_irq_o |=> !overflow_irq_o [*8]; endproperty
    property p_ovf_tick; overflow_irq_o |-> $past(src_tick_i); endproperty
    property p_frm_ovf; frame_irq_o |-> overflow_irq_o; endproperty
    property p_frm_gap; frame_irq_o |=> !frame_irq_o [*8]; endproperty
    property p_freeze; !ce_i |=> $stable(pwm_output_n_o); endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
    a_err: assert property (p_err) else $error("error read not zero");
    a_ovf_gap: assert property (p_ovf_gap) else $error("overflow too soon");
    a_ovf_tick: assert property (p_ovf_tick) else $error("overflow without tick");
    a_frm_ovf: assert property (p_frm_ovf) else $error("frame without overflow");
    a_frm_gap: assert property (p_frm_gap) else $error("frame too soon");
    a_freeze: assert property (p_freeze) else $error("pin moved while frozen");
endmodule : cpw_pwm12_chk
bind cpw_pwm12 cpw_pwm12_chk u_cpw_pwm12_chk (.clk_i, .rst_b_i, .ce_i, .psel_i, .penable_i,
    .pwrite_i, .src_tick_i, .prdata_o, .pready_o, .pslverr_o, .pwm_output_n_o,
    .overflow_irq_o, .frame_irq_o);
`default_nettype wire

// File: verification/test_cpw_pwm12.sv
`default_nettype none
module test_cpw_pwm12;
    timeunit 1ns;
    timeprecision 1ps;
    import cpw_pkg::*;
    logic clk_i = 0, rst_b_i = 0, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, e;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, q, prdata_o;
    logic pready_o, pslverr_o, pwm_output_n_o, overflow_irq_o, frame_irq_o;
    int err_total = 0, cmp_count = 0, cyc = 0;
    logic [1:0] ext_div = 2'h0;
    always #2 clk_i = ~clk_i;
    // external count pin: two clocks high, two low, half rate at most
    always @(posedge clk_i) ext_div <= ext_div + 2'h1;
    cpw_pwm12 u_cpw_pwm12 (.clk_i, .rst_b_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .src_tick_i(1'b1),
        .external_count_pin_i(ext_div[1]), .pwm_output_n_o, .overflow_irq_o, .frame_irq_o);
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 20);
        q = prdata_o;
        e = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
        if (n >= 20) err_total++;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, q, x);
    endtask : rd
    task automatic wait_on(input bit frm);
        int n = 0;
        do @(posedge clk_i); while (((frm ? frame_irq_o : overflow_irq_o) !== 1'b1) && ++n < 5000);
        if (n >= 5000) err_total++;
    endtask : wait_on
    task automatic meas(input int x);
        int h = 0, o = 0, f = 0;
        repeat (600) @(posedge clk_i);
        repeat (4096) begin
            @(posedge clk_i);
            h += (pwm_output_n_o === 1'b1);
            o += (overflow_irq_o === 1'b1);
            f += (frame_irq_o === 1'b1);
        end
        chk("frame high", h, x);
        chk("overflows", o, 16);
        chk("frames", f, 1);
    endtask : meas
    task automatic per(input int x);
        int h = 0;
        wait_on(1'b0);
        repeat (256) begin
            @(posedge clk_i);
            h += (pwm_output_n_o === 1'b1);
        end
        chk("period high", h, x);
    endtask : per
    task automatic t_reset;
        rd(CPW_ADDR_DUTY_LO, CPW_DUTY_LO_RST, "duty lo");
        rd(CPW_ADDR_DUTY_HI, CPW_DUTY_HI_RST, "duty hi");
        rd(CPW_ADDR_MODE, CPW_MODE_RST, "mode");
        rd(12'h0FC, 32'h0, "unmapped");
        chk("slverr", e, 1'b1);
        chk("pin", pwm_output_n_o, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_pwm(input logic l, input logic [3:0] x, input logic [7:0] d);
        wr(CPW_ADDR_CTRL, 32'h0);
        wr(CPW_ADDR_MODE, 32'h08 | l);
        repeat (2) @(posedge clk_i);
        chk("idle pin", pwm_output_n_o, l);
        wr(CPW_ADDR_DUTY_LO, {d[3:0], x});
        wr(CPW_ADDR_DUTY_HI, {4'hA, d[7:4]});
        rd(CPW_ADDR_DUTY_HI, {4'hA, d[7:4]}, "duty hi");
        wr(CPW_ADDR_CTRL, 32'h05);
        wr(CPW_ADDR_MODE, 32'h0);
        rd(CPW_ADDR_MODE, 32'h08 | l, "mode locked");
        meas(l ? 16 * d + x : 16 * (256 - d) - x);
        ce_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        ce_i <= 1'b1;
        wr(CPW_ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk_i);
        apb(1'b0, CPW_ADDR_STATUS, 32'h0);
        chk("stopped", {q[12], q[7:0]}, {l, 8'h00});
        chk("stop pin", pwm_output_n_o, l);
        $display("test pwm done");
    endtask : t_pwm
    task automatic t_buf;
        wr(CPW_ADDR_MODE, 32'h0A);
        wr(CPW_ADDR_DUTY_LO, 32'h0);
        wr(CPW_ADDR_DUTY_HI, 32'h04);
        wr(CPW_ADDR_CTRL, 32'h05);
        per(192);
        wait_on(1'b1);
        wr(CPW_ADDR_DUTY_HI, 32'h08);
        rd(CPW_ADDR_DUTY_HI, 32'h08, "buffered hi");
        per(192);
        wait_on(1'b1);
        per(128);
        wr(CPW_ADDR_CTRL, 32'h0);
        wr(CPW_ADDR_MODE, 32'h08);
        wr(CPW_ADDR_CTRL, 32'h05);
        wait_on(1'b0);
        wr(CPW_ADDR_DUTY_HI, 32'h04);
        per(192);
        $display("test buffer done");
    endtask : t_buf
    task automatic t_ext;
        int h = 0;
        wr(CPW_ADDR_CTRL, 32'h0);
        wr(CPW_ADDR_MODE, 32'h18);
        wr(CPW_ADDR_DUTY_LO, 32'h0);
        wr(CPW_ADDR_DUTY_HI, 32'h04);
        wr(CPW_ADDR_CTRL, 32'h05);
        wait_on(1'b0);
        repeat (1024) begin
            @(posedge clk_i);
            h += (pwm_output_n_o === 1'b1);
        end
        chk("ext period high", h, 768);
        wr(CPW_ADDR_CTRL, 32'h0);
        $display("test external clock done");
    endtask : t_ext
    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset;
        t_pwm(1'b0, 4'h0, 8'h40);
        t_pwm(1'b1, 4'h1, 8'h40);
        t_pwm(1'b0, 4'h2, 8'h40);
        t_pwm(1'b1, 4'h4, 8'h40);
        t_pwm(1'b0, 4'h8, 8'h40);
        t_pwm(1'b1, 4'hF, 8'h40);
        t_buf;
        t_ext;
        final_report;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            final_report;
        end
    end
endmodule : test_cpw_pwm12
`default_nettype wire
